// ---- design/mrch_pkg.sv ----
// constants, types and helpers shared by the register command handler
package mrch_pkg;
  localparam int REG_COUNT = 16;
  localparam int ADDR_W = 4;
  localparam int LW_COUNT = REG_COUNT / 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] GROUP_ID = 8'h00;
  localparam logic [7:0] DEV_LOCAL = 8'h00;
  localparam logic [7:0] BIT_MAX = 8'h07;
  localparam logic [2:0] BUF_MAX = 3'h7;
  localparam logic [2:0] LEN_BYTE = 3'h3;
  localparam logic [2:0] LEN_BIT = 3'h4;
  localparam logic [2:0] LEN_LONG = 3'h7;
  localparam logic [2:0] RSP_SHORT = 3'h2;
  localparam logic [2:0] RSP_BYTE = 3'h3;
  localparam logic [2:0] RSP_LONG = 3'h6;
  // command codes
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_SET = 8'h03;
  localparam logic [7:0] CMD_CLR = 8'h04;
  localparam logic [7:0] CMD_PLO = 8'h05;
  localparam logic [7:0] CMD_PHI = 8'h06;
  localparam logic [7:0] CMD_LREAD = 8'h07;
  // completion codes
  localparam logic [7:0] CC_OK = 8'h00;
  localparam logic [7:0] CC_BAD_CMD = 8'hC1;
  localparam logic [7:0] CC_BAD_LEN = 8'hC7;
  localparam logic [7:0] CC_RANGE = 8'hC9;
  localparam logic [7:0] CC_BAD_FIELD = 8'hCC;
  // pulse width
  localparam int CLK_PERIOD_NS = 5;
  localparam int PULSE_NS = 100;
  localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_CHECK = 3'h3,
    ST_RDADR = 3'h2,
    ST_RDCAP = 3'h6,
    ST_WRITE = 3'h7,
    ST_PULSE = 3'h5,
    ST_RESP = 3'h4
  } mrch_state_type;

  function automatic logic [7:0] bit_mask(input logic [7:0] idx);
    bit_mask = 8'h01 << idx[2:0];
  endfunction

  function automatic logic [7:0] reg_byte(input logic [REG_COUNT*8-1:0] regs,
                                          input logic [ADDR_W-1:0] addr);
    reg_byte = regs[addr*8 +: 8];
  endfunction
endpackage

// ---- design/mrch_regfile.sv ----
// byte-wide register array with registered read port and parallel view
module mrch_regfile (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [mrch_pkg::ADDR_W-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [mrch_pkg::ADDR_W-1:0] raddr_i,
  output logic [7:0] rdata_o,
  output logic [mrch_pkg::REG_COUNT*8-1:0] regs_o
);
  typedef struct packed {
    logic [mrch_pkg::REG_COUNT-1:0][7:0] mem;
    logic [7:0] rdata;
  } mrch_rf_type;

  mrch_rf_type s_r;
  mrch_rf_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = s_r.mem[raddr_i];
    if (we_i) begin
      s_nxt.mem[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_r <= {{mrch_pkg::REG_COUNT{mrch_pkg::REG_RESET}}, 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign regs_o = s_r.mem;
endmodule // mrch_regfile

// ---- design/mrch_cmd_handler.sv ----
// management message decoder that reads and modifies the byte registers

// Overview of operation
// (RL1) requests lead 0x00 0x00; responses lead code, 0x00
// (RL2) read returns register named by byte 3
// (RL3) write stores byte 4 into register byte 3
// (RL4) set-bit sets indexed bit, others unchanged
// (RL5) clear-bit clears indexed bit, others unchanged
// (RL6) pulse-low drives bit low briefly, then high
// (RL7) pulse-high drives bit high briefly, then low
// (RL8) long read: device, 32-bit number; LSB first reply
// (RL9) bad register, device or bit: error, no change
module mrch_cmd_handler (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire logic [7:0] req_cmd_i,
  input wire logic [7:0] req_data_i,
  input wire logic req_last_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_last_o,
  input wire logic rsp_ready_i,
  output logic [mrch_pkg::REG_COUNT*8-1:0] regs_o
);
  typedef struct packed {
    mrch_pkg::mrch_state_type st;
    logic [7:0] cmd;
    logic [6:0][7:0] rq;
    logic [2:0] len;
    logic [7:0] cc;
    logic [3:0][7:0] lw;
    logic [7:0] cnt;
    logic pdone;
    logic [2:0] idx;
    logic [2:0] nrsp;
    logic [7:0] rsp_data;
    logic rsp_last;
  } mrch_ctl_type;

  mrch_ctl_type s_r;
  mrch_ctl_type s_nxt;
  logic mem_we;
  logic [mrch_pkg::ADDR_W-1:0] mem_waddr;
  logic [mrch_pkg::ADDR_W-1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [7:0] mask;
  logic [31:0] lnum;
  logic [2:0] need;

  function automatic logic [7:0] resp_byte(input logic [2:0] idx, input logic [7:0] cc,
                                           input logic [3:0][7:0] lw);
    if (idx == 3'h0) begin
      resp_byte = cc;
    end else if (idx == 3'h1) begin
      resp_byte = mrch_pkg::GROUP_ID;
    end else begin
      resp_byte = lw[2'(idx - 3'h2)];
    end
  endfunction

  assign mask = mrch_pkg::bit_mask(s_r.rq[3]);
  // register number arrives most significant byte first
  assign lnum = {s_r.rq[3], s_r.rq[4], s_r.rq[5], s_r.rq[6]};
  assign mem_waddr = s_r.rq[2][mrch_pkg::ADDR_W-1:0];
  assign mem_raddr = (s_r.cmd == mrch_pkg::CMD_LREAD) ? {s_r.rq[6][1:0], s_r.cnt[1:0]}
                                                      : s_r.rq[2][mrch_pkg::ADDR_W-1:0];

  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    need = mrch_pkg::LEN_BIT;
    if (s_r.cmd == mrch_pkg::CMD_READ) begin
      need = mrch_pkg::LEN_BYTE;
    end else if (s_r.cmd == mrch_pkg::CMD_LREAD) begin
      need = mrch_pkg::LEN_LONG;
    end
    case (s_r.st)
      mrch_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          s_nxt.cmd = req_cmd_i;
          s_nxt.rq[0] = req_data_i;
          s_nxt.len = 3'h1;
          s_nxt.st = req_last_i ? mrch_pkg::ST_CHECK : mrch_pkg::ST_RECV;
        end
      end
      mrch_pkg::ST_RECV: begin
        // bytes past the longest request are dropped, not refused
        if (req_valid_i) begin
          if (s_r.len < mrch_pkg::BUF_MAX) begin
            s_nxt.rq[s_r.len] = req_data_i;
            s_nxt.len = s_r.len + 3'h1;
          end
          if (req_last_i) begin
            s_nxt.st = mrch_pkg::ST_CHECK;
          end
        end
      end
      mrch_pkg::ST_CHECK: begin
        s_nxt.cc = mrch_pkg::CC_OK;
        s_nxt.cnt = 8'h00;
        s_nxt.lw = '0;
        if (s_r.len < 3'h2 || s_r.rq[0] != mrch_pkg::GROUP_ID
            || s_r.rq[1] != mrch_pkg::GROUP_ID) begin
          s_nxt.cc = mrch_pkg::CC_BAD_FIELD; // [RL1]
        end else if (s_r.cmd < mrch_pkg::CMD_READ || s_r.cmd > mrch_pkg::CMD_LREAD) begin
          s_nxt.cc = mrch_pkg::CC_BAD_CMD;
        end else if (s_r.len < need) begin
          s_nxt.cc = mrch_pkg::CC_BAD_LEN;
        end else if (s_r.cmd == mrch_pkg::CMD_LREAD) begin
          if (s_r.rq[2] != mrch_pkg::DEV_LOCAL || lnum >= 32'(mrch_pkg::LW_COUNT)) begin
            s_nxt.cc = mrch_pkg::CC_RANGE; // [RL9]
          end
        end else if (s_r.rq[2] >= 8'(mrch_pkg::REG_COUNT)) begin
          s_nxt.cc = mrch_pkg::CC_RANGE; // [RL9]
        end else if (s_r.cmd != mrch_pkg::CMD_READ && s_r.cmd != mrch_pkg::CMD_WRITE
                     && s_r.rq[3] > mrch_pkg::BIT_MAX) begin
          s_nxt.cc = mrch_pkg::CC_RANGE; // [RL9]
        end
        s_nxt.nrsp = mrch_pkg::RSP_SHORT;
        if (s_nxt.cc != mrch_pkg::CC_OK) begin
          s_nxt.st = mrch_pkg::ST_RESP;
        end else if (s_r.cmd == mrch_pkg::CMD_WRITE) begin
          s_nxt.lw[0] = s_r.rq[3]; // [RL3]
          s_nxt.pdone = 1'b0;
          s_nxt.st = mrch_pkg::ST_WRITE;
        end else begin
          if (s_r.cmd == mrch_pkg::CMD_READ) begin
            s_nxt.nrsp = mrch_pkg::RSP_BYTE; // [RL2]
          end else if (s_r.cmd == mrch_pkg::CMD_LREAD) begin
            s_nxt.nrsp = mrch_pkg::RSP_LONG; // [RL8]
          end
          s_nxt.st = mrch_pkg::ST_RDADR;
        end
        s_nxt.idx = 3'h0;
        s_nxt.rsp_data = s_nxt.cc; // [RL1]
        s_nxt.rsp_last = 1'b0;
      end
      mrch_pkg::ST_RDADR: begin
        s_nxt.st = mrch_pkg::ST_RDCAP;
      end
      mrch_pkg::ST_RDCAP: begin
        s_nxt.pdone = 1'b0;
        s_nxt.st = mrch_pkg::ST_WRITE;
        case (s_r.cmd)
          mrch_pkg::CMD_SET: s_nxt.lw[0] = mem_rdata | mask; // [RL4]
          mrch_pkg::CMD_CLR: s_nxt.lw[0] = mem_rdata & ~mask; // [RL5]
          mrch_pkg::CMD_PLO: s_nxt.lw[0] = mem_rdata & ~mask; // [RL6]
          mrch_pkg::CMD_PHI: s_nxt.lw[0] = mem_rdata | mask; // [RL7]
          default: begin
            // reply bytes fill least significant first
            s_nxt.lw[s_r.cnt[1:0]] = mem_rdata; // [RL2] [RL8]
            if (s_r.cmd == mrch_pkg::CMD_LREAD && s_r.cnt != 8'h03) begin
              s_nxt.cnt = s_r.cnt + 8'h01;
              s_nxt.st = mrch_pkg::ST_RDADR;
            end else begin
              s_nxt.st = mrch_pkg::ST_RESP;
            end
          end
        endcase
      end
      mrch_pkg::ST_WRITE: begin
        mem_we = 1'b1; // [RL3]
        s_nxt.cnt = 8'h00;
        if ((s_r.cmd == mrch_pkg::CMD_PLO || s_r.cmd == mrch_pkg::CMD_PHI) && !s_r.pdone) begin
          s_nxt.st = mrch_pkg::ST_PULSE;
        end else begin
          s_nxt.st = mrch_pkg::ST_RESP;
        end
      end
      mrch_pkg::ST_PULSE: begin
        // answer is held back until the bit is restored, so a reply means done
        // the restoring write costs one more cycle, so the count stops one short
        if (s_r.cnt == 8'(mrch_pkg::PULSE_CYC - 2)) begin
          s_nxt.lw[0] = s_r.lw[0] ^ mask; // [RL6] [RL7]
          s_nxt.pdone = 1'b1;
          s_nxt.st = mrch_pkg::ST_WRITE;
        end else begin
          s_nxt.cnt = s_r.cnt + 8'h01;
        end
      end
      mrch_pkg::ST_RESP: begin
        if (rsp_ready_i) begin
          if (s_r.rsp_last) begin
            s_nxt.st = mrch_pkg::ST_IDLE;
          end else begin
            s_nxt.idx = s_r.idx + 3'h1;
            s_nxt.rsp_data = resp_byte(s_nxt.idx, s_r.cc, s_r.lw); // [RL1]
            s_nxt.rsp_last = (s_nxt.idx == s_r.nrsp - 3'h1);
          end
        end
      end
      default: s_nxt.st = mrch_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  mrch_regfile u_regs (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(s_r.lw[0]),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata),
    .regs_o(regs_o)
  );

  assign req_ready_o = (s_r.st == mrch_pkg::ST_IDLE) || (s_r.st == mrch_pkg::ST_RECV);
  assign rsp_valid_o = (s_r.st == mrch_pkg::ST_RESP);
  assign rsp_data_o = s_r.rsp_data;
  assign rsp_last_o = s_r.rsp_last;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  group_id_a: assert property (rsp_valid_o && s_r.idx == 3'h1 |-> rsp_data_o == 8'h00) // [RL1]
    else $error("second reply byte is not the group id");
  read_value_a: assert property (rsp_valid_o && s_r.idx == 3'h2 && s_r.cmd == mrch_pkg::CMD_READ
      |-> rsp_data_o == mrch_pkg::reg_byte(regs_o, mem_waddr)) // [RL2]
    else $error("read reply differs from register");
  write_store_a: assert property ($rose(rsp_valid_o) && s_r.cmd == mrch_pkg::CMD_WRITE
      && s_r.cc == mrch_pkg::CC_OK
      |-> mrch_pkg::reg_byte(regs_o, mem_waddr) == s_r.rq[3] && s_r.nrsp == 3'h2) // [RL3]
    else $error("write did not store value");
  set_bit_a: assert property (mem_we && s_r.cmd == mrch_pkg::CMD_SET
      |=> (mrch_pkg::reg_byte(regs_o, mem_waddr) & mask) == mask) // [RL4]
    else $error("set bit not set");
  clr_bit_a: assert property (mem_we && s_r.cmd == mrch_pkg::CMD_CLR
      |=> (mrch_pkg::reg_byte(regs_o, mem_waddr) & mask) == 8'h00) // [RL5]
    else $error("clear bit not cleared");
  pulse_low_a: assert property ($fell(s_r.st == mrch_pkg::ST_PULSE) && s_r.cmd == mrch_pkg::CMD_PLO
      |-> $past(s_r.cnt) == 8'(mrch_pkg::PULSE_CYC - 2)
      && (mrch_pkg::reg_byte(regs_o, mem_waddr) & mask) == 8'h00
      ##1 (mrch_pkg::reg_byte(regs_o, mem_waddr) & mask) == mask) // [RL6]
    else $error("low pulse wrong");
  pulse_high_a: assert property ($fell(s_r.st == mrch_pkg::ST_PULSE)
      && s_r.cmd == mrch_pkg::CMD_PHI
      |-> (mrch_pkg::reg_byte(regs_o, mem_waddr) & mask) == mask
      ##1 (mrch_pkg::reg_byte(regs_o, mem_waddr) & mask) == 8'h00) // [RL7]
    else $error("high pulse wrong");
  long_lsb_a: assert property (rsp_valid_o && s_r.idx == 3'h2 && s_r.cmd == mrch_pkg::CMD_LREAD
      && s_r.cc == mrch_pkg::CC_OK
      |-> rsp_data_o == mrch_pkg::reg_byte(regs_o, {s_r.rq[6][1:0], 2'h0})) // [RL8]
    else $error("long read not least byte first");
  err_hold_a: assert property (s_r.cc != mrch_pkg::CC_OK && s_r.st == mrch_pkg::ST_RESP
      |-> !mem_we && s_r.nrsp == 3'h2 && $stable(regs_o)) // [RL9]
    else $error("error reply changed registers");

  read_c: cover property ($rose(rsp_valid_o) && s_r.cmd == mrch_pkg::CMD_READ);
  pulse_c: cover property ($fell(s_r.st == mrch_pkg::ST_PULSE));
  long_c: cover property (rsp_last_o && rsp_ready_i && s_r.cmd == mrch_pkg::CMD_LREAD);
  error_c: cover property ($rose(rsp_valid_o) && s_r.cc == mrch_pkg::CC_RANGE);
endmodule // mrch_cmd_handler

// ---- testbench/mrch_mgmt_model.sv ----
// management controller model: sends request bytes and takes reply bytes
module mrch_mgmt_model (
  input wire logic ref_clk_i,
  output logic req_valid_o,
  output logic [7:0] req_cmd_o,
  output logic [7:0] req_data_o,
  output logic req_last_o,
  input wire logic req_ready_i,
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_data_i,
  input wire logic rsp_last_i,
  output logic rsp_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rsp_q[$];
  bit slow = 1'b0;
  initial begin
    req_valid_o = 1'b0;
    req_cmd_o = 8'h00;
    req_data_o = 8'h00;
    req_last_o = 1'b0;
    rsp_ready_o = 1'b0;
  end
  // bytes go out in the order given, each held until taken
  task automatic send(input logic [7:0] cmd, input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++) begin
      req_valid_o = 1'b1;
      req_cmd_o = cmd;
      req_data_o = b[i];
      req_last_o = (i == b.size() - 1);
      while (req_ready_i !== 1'b1) @(negedge ref_clk_i);
      @(negedge ref_clk_i);
    end
    req_valid_o = 1'b0;
    req_last_o = 1'b0;
    // released lines flip so a stale byte is never mistaken for a live one
    req_data_o = ~req_data_o;
    req_cmd_o = ~req_cmd_o;
  endtask
  // slow mode stalls the reply stream at random
  task automatic recv();
    bit done;
    done = 1'b0;
    rsp_q.delete();
    for (int g = 0; g < 400 && !done; g++) begin
      rsp_ready_o = slow ? 1'($urandom_range(0, 1)) : 1'b1;
      if (rsp_valid_i === 1'b1 && rsp_ready_o) begin
        rsp_q.push_back(rsp_data_i);
        done = (rsp_last_i === 1'b1);
      end
      @(negedge ref_clk_i);
    end
    rsp_ready_o = 1'b0;
  endtask
endmodule // mrch_mgmt_model

// ---- testbench/mrch_cmd_handler_tb_top.sv ----
// self-checking bench for the register command handler
module mrch_cmd_handler_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
  logic [7:0] req_cmd, req_data, rsp_data;
  logic [127:0] regs;
  logic [7:0] exp_regs [16];
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int pbit = 0;
  int pcnt = 0;
  logic plev = 1'b0;
  bit pmon = 1'b0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  mrch_cmd_handler dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid),
    .req_cmd_i(req_cmd), .req_data_i(req_data), .req_last_i(req_last), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_last_o(rsp_last),
    .rsp_ready_i(rsp_ready), .regs_o(regs));
  mrch_mgmt_model mgmt (.ref_clk_i(ref_clk_i), .req_valid_o(req_valid), .req_cmd_o(req_cmd),
    .req_data_o(req_data), .req_last_o(req_last), .req_ready_i(req_ready),
    .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data), .rsp_last_i(rsp_last),
    .rsp_ready_o(rsp_ready));
  always @(negedge ref_clk_i) if (pmon && regs[8 * 3 + pbit] === plev) pcnt++;
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // reply bytes and register image that a request should produce
  function automatic void predict(input logic [7:0] cmd, input logic [7:0] b[$]);
    logic [7:0] cc;
    int need;
    logic [31:0] num;
    need = (cmd == mrch_pkg::CMD_READ) ? 3 : (cmd == mrch_pkg::CMD_LREAD) ? 7 : 4;
    num = 0;
    cc = mrch_pkg::CC_OK;
    if (b[0] != 8'h00 || b[1] != 8'h00) cc = mrch_pkg::CC_BAD_FIELD;
    else if (cmd < mrch_pkg::CMD_READ || cmd > mrch_pkg::CMD_LREAD) cc = mrch_pkg::CC_BAD_CMD;
    else if (b.size() < need) cc = mrch_pkg::CC_BAD_LEN;
    else if (cmd == mrch_pkg::CMD_LREAD) begin
      num = {b[3], b[4], b[5], b[6]};
      if (b[2] != mrch_pkg::DEV_LOCAL || num >= mrch_pkg::LW_COUNT) cc = mrch_pkg::CC_RANGE;
    end else if (b[2] >= 16 || (cmd > mrch_pkg::CMD_WRITE && b[3] > 8'h07)) begin
      cc = mrch_pkg::CC_RANGE;
    end
    exp_q = '{cc, mrch_pkg::GROUP_ID};
    if (cc != mrch_pkg::CC_OK) return;
    case (cmd)
      mrch_pkg::CMD_READ: exp_q.push_back(exp_regs[b[2]]);
      mrch_pkg::CMD_WRITE: exp_regs[b[2]] = b[3];
      mrch_pkg::CMD_SET, mrch_pkg::CMD_PLO: exp_regs[b[2]][b[3][2:0]] = 1'b1;
      mrch_pkg::CMD_CLR, mrch_pkg::CMD_PHI: exp_regs[b[2]][b[3][2:0]] = 1'b0;
      default: for (int i = 0; i < 4; i++) exp_q.push_back(exp_regs[4 * num + i]);
    endcase
  endfunction
  task automatic do_req(input logic [7:0] cmd, input logic [7:0] b[$]);
    predict(cmd, b);
    mgmt.send(cmd, b);
    chk("req_ready", req_ready, 1'b0);
    mgmt.recv();
    chk("rsp_len", mgmt.rsp_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < mgmt.rsp_q.size(); i++) begin
      chk("rsp_byte", mgmt.rsp_q[i], exp_q[i]);
    end
    for (int i = 0; i < 16; i++) begin
      chk("reg", regs[8 * i +: 8], exp_regs[i]);
    end
  endtask
  // bit starts at the idle level so every active cycle belongs to the pulse
  task automatic pulse_case(input logic [7:0] cmd, input logic [7:0] pre, input int pb);
    do_req(mrch_pkg::CMD_WRITE, '{8'h00, 8'h00, 8'h03, pre});
    pbit = pb;
    plev = (cmd == mrch_pkg::CMD_PHI);
    pcnt = 0;
    pmon = 1'b1;
    do_req(cmd, '{8'h00, 8'h00, 8'h03, 8'(pb)});
    pmon = 1'b0;
    chk("pulse_width", pcnt, mrch_pkg::PULSE_CYC);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #300us;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] c;
    logic [7:0] b[$];
    c = 8'($urandom(70));
    foreach (exp_regs[i]) exp_regs[i] = mrch_pkg::REG_RESET;
    repeat (4) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk("rsp_valid", rsp_valid, 1'b0);
    do_req(mrch_pkg::CMD_WRITE, '{8'h01, 8'h00, 8'h02, 8'h55});
    do_req(mrch_pkg::CMD_READ, '{8'h00, 8'h80, 8'h02});
    do_req(8'h08, '{8'h00, 8'h00, 8'h02});
    do_req(8'h00, '{8'h00, 8'h00, 8'h02});
    do_req(mrch_pkg::CMD_READ, '{8'h00, 8'h00});
    do_req(mrch_pkg::CMD_SET, '{8'h00, 8'h00, 8'h01});
    do_req(mrch_pkg::CMD_LREAD, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    do_req(mrch_pkg::CMD_WRITE, '{8'h00, 8'h00, 8'h0F, 8'hA5});
    do_req(mrch_pkg::CMD_READ, '{8'h00, 8'h00, 8'h0F});
    do_req(mrch_pkg::CMD_SET, '{8'h00, 8'h00, 8'h10, 8'h00});
    do_req(mrch_pkg::CMD_CLR, '{8'h00, 8'h00, 8'h0F, 8'h08});
    do_req(mrch_pkg::CMD_LREAD, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00});
    do_req(mrch_pkg::CMD_LREAD, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03});
    pulse_case(mrch_pkg::CMD_PLO, 8'hFF, 2);
    pulse_case(mrch_pkg::CMD_PHI, 8'h00, 5);
    for (int k = 0; k < 80; k++) begin
      c = 8'($urandom_range(1, 7));
      mgmt.slow = k[0];
      b = '{8'h00, 8'h00, 8'($urandom_range(0, 17)), 8'($urandom_range(0, 9))};
      if (c == mrch_pkg::CMD_WRITE) b[3] = 8'($urandom);
      if (c == mrch_pkg::CMD_READ) b.pop_back();
      if (c == mrch_pkg::CMD_LREAD) begin
        b = '{8'h00, 8'h00, 8'($urandom_range(0, 1)), 8'h00, 8'h00, 8'h00,
          8'($urandom_range(0, 4))};
      end
      do_req(c, b);
    end
    tally_and_finish();
  end
endmodule // mrch_cmd_handler_tb_top
